// file: inc/hmrfw_consts.vh
// Purpose: constants of the receive filter and wake detect block
// Assumes: included by its bare name from the design file
// Notes: byte addresses of the AXI4-Lite register map, fields, resets
`ifndef HMRFW_CONSTS_VH
`define HMRFW_CONSTS_VH
// ******
// register byte addresses
// ******
`define HMRFW_ADDR_RX_CFG 8'h00
`define HMRFW_ADDR_FLOW 8'h04
`define HMRFW_ADDR_STA_LOW 8'h08
`define HMRFW_ADDR_STA_HIGH 8'h0C
`define HMRFW_ADDR_WAKE_CSR 8'h10
`define HMRFW_ADDR_PM_CTRL 8'h14
`define HMRFW_ADDR_FILT_PORT 8'h18
// ******
// field positions
// ******
`define HMRFW_RECEIVE_ALL_MODE_BIT 0
`define HMRFW_BCDIS_BIT 1
`define HMRFW_PASS_BAD_FRAMES_BIT 2
`define HMRFW_SOFTRST_BIT 31
`define HMRFW_PASSCTL_BIT 0
`define HMRFW_PFEN_BIT 0
`define HMRFW_BCEN_BIT 1
`define HMRFW_WFEN_BIT 2
`define HMRFW_MAGIC_PACKET_WAKE_ENABLE_BIT 3
`define HMRFW_WAITSLP_BIT 4
`define HMRFW_PFFR_BIT 8
`define HMRFW_BCFR_BIT 9
`define HMRFW_WFFR_BIT 10
`define HMRFW_MPFR_BIT 11
`define HMRFW_WAKEEN_BIT 0
`define HMRFW_WAKESTS_BIT 1
// ******
// filter array layout, reset values, frame figures
// ******
`define HMRFW_FILT_WORDS 40
`define HMRFW_FILT_LAST 6'h27
`define HMRFW_CMD_BASE 32
`define HMRFW_OFS_BASE 34
`define HMRFW_CRC_BASE 36
`define HMRFW_MASK_BYTES 9'h080
`define HMRFW_SHORT_LEN 9'h03C
`define HMRFW_CRC_PRESET 16'hFFFF
`define HMRFW_RESP_OKAY 2'h0
`define HMRFW_RESP_SLVERR 2'h2
`define HMRFW_RST_WORD 32'h00000000
`endif

// file: rtl/hmrfw_core.v
// What this block does
// RULE1: good frame passing address filter kept, filter-fail clear, packet-filter set
// RULE2: good frame failing filter kept only in receive-all, both flags set
// RULE3: broadcast kept on pass or receive-all; packet-filter is inverse of broadcast-disable
// RULE4: control frame kept on pass or receive-all; packet-filter follows pass-control
// RULE5: errored frame over 60 bytes kept on pass or receive-all; flag follows pass-bad
// RULE6: errored frame up to 60 bytes kept on pass, or receive-all with pass-bad
// RULE7: four wake enables: perfect address, broadcast, pattern frame, magic packet
// RULE8: wait-for-sleep holds off all wake detection until power-down
// RULE9: wake reported in status bit; request out only with wake-event enable
// RULE10: perfect-address wake suspends reception; address match sets its flag
// RULE11: broadcast wake suspends reception; all-ones address sets its flag
// RULE12: pattern wake suspends reception; pattern detection sets its flag
// RULE13: reception resumes once software clears the suspending enable
// RULE14: eight filters, 128-bit byte mask feeding CRC-16, compared to expected
// RULE15: port writes load consecutive filter words from word 0 after reset
// RULE16: port reads return filter words in order, 40 reads cover all
// RULE17: host writes all 40 filter words before enabling pattern wake
// RULE18: pattern wake needs the filter address-type check and a CRC match
// RULE19: mask bit j selects frame byte at offset plus j
// RULE20: host programs each pattern offset above 12
// RULE21: at frame end computed CRC equal to expected signals a wake
// RULE22: CRC preset to all ones each frame, updated on selected bytes only
// RULE23: command bit 0 enables a filter; disabled filter never matches
// RULE24: address type 00 unicast, 10 multicast, x1 any frame passing filter
// RULE25: mask word lsb is the earliest byte of its 32 bytes
// RULE26: wake flags sticky until cleared; detection leaves filter pointer alone
//
// Purpose: receive acceptance and wake-on-LAN detection of the host MAC
// Assumes: frame bytes and their status come from logic on ref_clk
// Notes: address filter verdict is computed upstream and sampled at frame end
`timescale 1ns/1ps
`default_nettype none
`include "hmrfw_consts.vh"
module hmrfw_core (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // AXI4-Lite write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // received frame bytes from the fabric port
   input wire rxValid,
   input wire rxSof,
   input wire rxEof,
   input wire [7:0] rxData,
   // frame status, valid with the last byte
   input wire rxCrcErr,
   input wire rxRunt,
   input wire rxCollision,
   input wire rxTooLong,
   input wire rxControl,
   input wire addrFilterPass,
   // power management side
   input wire powerDown,
   input wire magicPacketDetect,
   // per-frame verdict, one-cycle pulse with its flags
   output reg statValid,
   output reg statKeep,
   output reg statFilterFail,
   output reg statPacketFilter,
   // wake request towards event and interrupt pins
   output reg wakeRequest
);
   // ******
   // register state
   // ******
   reg receiveAllMode;
   reg broadcastDisable;
   reg passBadFrames;
   reg passControlFrames;
   reg [31:0] stationAddressLow;
   reg [15:0] stationAddressHigh;
   reg perfectAddressWakeEnable;
   reg broadcastWakeEnable;
   reg wakeFrameEnable;
   reg magicPacketWakeEnable;
   reg wakeWaitForSleep;
   reg perfectAddressFrameReceived;
   reg broadcastFrameReceived;
   reg wakeFrameReceived;
   reg magicFrameReceived;
   reg wakeEventEnable;
   reg wakeEventStatus;
   reg [5:0] filtPtr;
   reg [31:0] filtMem [0:`HMRFW_FILT_WORDS-1];
   reg [7:0] awAddrQ;
   reg [31:0] wDataQ;
   reg [3:0] wStrbQ;
   // frame tracking
   reg [8:0] byteCnt;
   reg [8:0] frameLen;
   reg [47:0] destAddr;
   reg frameDone;
   reg frameGood;
   reg frameCtl;
   reg framePass;
   wire [7:0] hitVec;
   integer i;

   wire rdDo = s_axi_arvalid && s_axi_arready;
   // the holding registers are full while the matching ready is low
   wire wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !rdDo;
   wire wrPort = wrDo && (awAddrQ == `HMRFW_ADDR_FILT_PORT);
   wire rdPort = rdDo && (s_axi_araddr == `HMRFW_ADDR_FILT_PORT);
   wire softReset = wrDo && (awAddrQ == `HMRFW_ADDR_RX_CFG)
                    && wStrbQ[3] && wDataQ[`HMRFW_SOFTRST_BIT];
   wire [8:0] cntNow = rxSof ? 9'h000 : byteCnt;
   wire [31:0] wMerged = {wStrbQ[3] ? wDataQ[31:24] : 8'h00,
                          wStrbQ[2] ? wDataQ[23:16] : 8'h00,
                          wStrbQ[1] ? wDataQ[15:8] : 8'h00,
                          wStrbQ[0] ? wDataQ[7:0] : 8'h00};
   wire [31:0] wKeepMask = {{8{!wStrbQ[3]}}, {8{!wStrbQ[2]}},
                            {8{!wStrbQ[1]}}, {8{!wStrbQ[0]}}};

   // CRC-16 step over one byte, data bit 0 first
   function [15:0] crcStep;
      input [15:0] c;
      input [7:0] d;
      reg [7:0] f;
      begin
         f[0] = c[15] ^ d[0];
         f[1] = c[14] ^ f[0] ^ d[1];
         f[2] = c[13] ^ f[1] ^ d[2];
         f[3] = c[12] ^ f[2] ^ d[3];
         f[4] = c[11] ^ f[3] ^ d[4];
         f[5] = c[10] ^ f[4] ^ d[5];
         f[6] = c[9] ^ f[5] ^ d[6];
         f[7] = c[8] ^ f[6] ^ d[7];
         crcStep = {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1],
                    f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4], f[3] ^ f[5],
                    f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
      end
   endfunction

   // ******
   // frame byte counting and destination address capture
   // ******
   // counter saturates so very long frames cannot wrap into a mask window
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         byteCnt <= 9'h000;
         frameLen <= 9'h000;
         destAddr <= 48'h000000000000;
         frameDone <= 1'b0;
         frameGood <= 1'b0;
         frameCtl <= 1'b0;
         framePass <= 1'b0;
      end
      else
      begin
         frameDone <= rxValid && rxEof;
         if (rxValid)
         begin
            byteCnt <= (cntNow == 9'h1FF) ? cntNow : cntNow + 9'h001;
            if (cntNow < 9'h006)
               destAddr <= {rxData, destAddr[47:8]};
            if (rxEof)
            begin
               frameLen <= (cntNow == 9'h1FF) ? cntNow : cntNow + 9'h001;
               frameGood <= !(rxCrcErr || rxRunt || rxCollision || rxTooLong);
               frameCtl <= rxControl;
               framePass <= addrFilterPass;
            end
         end
      end
   end

   wire isBroadcast = (destAddr == 48'hFFFFFFFFFFFF);
   wire isMulticast = destAddr[0];
   wire addrMatch = (destAddr == {stationAddressHigh, stationAddressLow});
   // with wait-for-sleep set, wake detection runs only once the host has put the device to sleep
   // RULE8: sleep gate
   wire wakeArmed = !wakeWaitForSleep || powerDown;

   // ******
   // eight pattern filters
   // ******
   // RULE14: eight filters
   genvar f;
   generate
      for (f = 0; f < 8; f = f + 1)
      begin : gFilt
         localparam [5:0] MBASE = f * 4;
         localparam integer CBIT = (f % 4) * 8;
         localparam integer KBIT = (f % 2) * 16;
         reg [15:0] crc;
         wire [3:0] cmd = filtMem[`HMRFW_CMD_BASE + f / 4][CBIT +: 4];
         wire [7:0] ofs = filtMem[`HMRFW_OFS_BASE + f / 4][CBIT +: 8];
         wire [15:0] expCrc = filtMem[`HMRFW_CRC_BASE + f / 2][KBIT +: 16];
         wire [8:0] rel = cntNow - {1'b0, ofs};
         wire [5:0] mIdx = MBASE + {4'h0, rel[6:5]};
         wire [31:0] maskWord = filtMem[mIdx];
         // RULE19: offset plus j
         // RULE25: lsb first byte
         wire selByte = (cntNow >= {1'b0, ofs}) && (rel < `HMRFW_MASK_BYTES)
                        && maskWord[rel[4:0]];
         wire [15:0] crcBase = rxSof ? `HMRFW_CRC_PRESET : crc;
         // RULE24: address type
         wire typeOk = cmd[2] ? framePass
                       : (framePass && (isMulticast == cmd[3]));
         // RULE22: preset and masked update
         always @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
               crc <= `HMRFW_CRC_PRESET;
            else if (rxValid)
               crc <= selByte ? crcStep(crcBase, rxData) : crcBase;
         end
         // RULE23: enable bit
         // RULE18: type and CRC
         // RULE21: final compare
         assign hitVec[f] = cmd[0] && typeOk && (crc == expCrc) && frameGood;
      end
   endgenerate

   // ******
   // frame verdict
   // ******
   // normal reception stops while perfect-address, broadcast or pattern wake is selected; magic packet wake leaves it running
   // RULE13: resume on clear
   wire rxSuspended = perfectAddressWakeEnable || broadcastWakeEnable || wakeFrameEnable;
   reg nextKeep;
   reg nextPf;
   always @*
   begin
      nextKeep = framePass || receiveAllMode;
      nextPf = 1'b1;
      if (frameGood)
      begin
         if (isBroadcast)
            // RULE3: broadcast flag
            nextPf = !broadcastDisable;
         else if (frameCtl)
            // RULE4: control flag
            nextPf = passControlFrames;
         else
            // RULE1: good pass
            // RULE2: receive-all
            nextPf = 1'b1;
      end
      else if (frameLen > `HMRFW_SHORT_LEN)
         // RULE5: long errored
         nextPf = passBadFrames;
      else
         // RULE6: short errored
         nextKeep = framePass || (receiveAllMode && passBadFrames);
   end

   // verdict leaves one cycle after frame end, two after the last byte
   // RULE10: suspend reception
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         statValid <= 1'b0;
         statKeep <= 1'b0;
         statFilterFail <= 1'b0;
         statPacketFilter <= 1'b0;
      end
      else
      begin
         statValid <= frameDone;
         if (frameDone)
         begin
            statKeep <= nextKeep && !rxSuspended;
            statFilterFail <= !framePass;
            statPacketFilter <= nextPf;
         end
      end
   end

   // ******
   // wake hits
   // ******
   // RULE7: four enables
   // RULE10: address match
   wire pfHit = frameDone && wakeArmed && perfectAddressWakeEnable && frameGood && addrMatch;
   // RULE11: all-ones address
   wire bcHit = frameDone && wakeArmed && broadcastWakeEnable && frameGood && isBroadcast;
   // RULE12: pattern hit
   wire wfHit = frameDone && wakeArmed && wakeFrameEnable && (|hitVec);
   wire mpHit = wakeArmed && magicPacketWakeEnable && magicPacketDetect;
   wire csrWr = wrDo && (awAddrQ == `HMRFW_ADDR_WAKE_CSR);
   wire pmWr = wrDo && (awAddrQ == `HMRFW_ADDR_PM_CTRL);
   wire [31:0] clr = csrWr ? wMerged : 32'h00000000;
   wire [31:0] pmClr = pmWr ? wMerged : 32'h00000000;

   // ******
   // filter array port
   // ******
   // RULE15: sequential load
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (i = 0; i < `HMRFW_FILT_WORDS; i = i + 1)
            filtMem[i] <= `HMRFW_RST_WORD;
      end
      else if (wrPort)
         filtMem[filtPtr] <= (filtMem[filtPtr] & wKeepMask) | wMerged;
   end

   // ******
   // AXI4-Lite slave and control registers
   // ******
   // write address and data are held separately, so either may come first
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `HMRFW_RESP_OKAY;
         awAddrQ <= 8'h00;
         wDataQ <= 32'h00000000;
         wStrbQ <= 4'h0;
         receiveAllMode <= 1'b0;
         broadcastDisable <= 1'b0;
         passBadFrames <= 1'b0;
         passControlFrames <= 1'b0;
         stationAddressLow <= 32'h00000000;
         stationAddressHigh <= 16'h0000;
         perfectAddressWakeEnable <= 1'b0;
         broadcastWakeEnable <= 1'b0;
         wakeFrameEnable <= 1'b0;
         magicPacketWakeEnable <= 1'b0;
         wakeWaitForSleep <= 1'b0;
         perfectAddressFrameReceived <= 1'b0;
         broadcastFrameReceived <= 1'b0;
         wakeFrameReceived <= 1'b0;
         magicFrameReceived <= 1'b0;
         wakeEventEnable <= 1'b0;
         wakeEventStatus <= 1'b0;
         wakeRequest <= 1'b0;
         filtPtr <= 6'h00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awAddrQ <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wrDo)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `HMRFW_RESP_OKAY;
            if (awAddrQ == `HMRFW_ADDR_RX_CFG)
            begin
               if (wStrbQ[0])
               begin
                  receiveAllMode <= wDataQ[`HMRFW_RECEIVE_ALL_MODE_BIT];
                  broadcastDisable <= wDataQ[`HMRFW_BCDIS_BIT];
                  passBadFrames <= wDataQ[`HMRFW_PASS_BAD_FRAMES_BIT];
               end
            end
            else if (awAddrQ == `HMRFW_ADDR_FLOW)
            begin
               if (wStrbQ[0])
                  passControlFrames <= wDataQ[`HMRFW_PASSCTL_BIT];
            end
            else if (awAddrQ == `HMRFW_ADDR_STA_LOW)
               stationAddressLow <= (stationAddressLow & wKeepMask) | wMerged;
            else if (awAddrQ == `HMRFW_ADDR_STA_HIGH)
               stationAddressHigh <= (stationAddressHigh & wKeepMask[15:0]) | wMerged[15:0];
            else if (awAddrQ == `HMRFW_ADDR_WAKE_CSR)
            begin
               if (wStrbQ[0])
               begin
                  perfectAddressWakeEnable <= wDataQ[`HMRFW_PFEN_BIT];
                  broadcastWakeEnable <= wDataQ[`HMRFW_BCEN_BIT];
                  wakeFrameEnable <= wDataQ[`HMRFW_WFEN_BIT];
                  magicPacketWakeEnable <= wDataQ[`HMRFW_MAGIC_PACKET_WAKE_ENABLE_BIT];
                  wakeWaitForSleep <= wDataQ[`HMRFW_WAITSLP_BIT];
               end
            end
            else if (awAddrQ == `HMRFW_ADDR_PM_CTRL)
            begin
               if (wStrbQ[0])
                  wakeEventEnable <= wDataQ[`HMRFW_WAKEEN_BIT];
            end
            else if (awAddrQ != `HMRFW_ADDR_FILT_PORT)
               s_axi_bresp <= `HMRFW_RESP_SLVERR;
         end
         // RULE26: sticky, set wins
         perfectAddressFrameReceived <= pfHit
            || (perfectAddressFrameReceived && !clr[`HMRFW_PFFR_BIT]);
         broadcastFrameReceived <= bcHit || (broadcastFrameReceived && !clr[`HMRFW_BCFR_BIT]);
         wakeFrameReceived <= wfHit || (wakeFrameReceived && !clr[`HMRFW_WFFR_BIT]);
         magicFrameReceived <= mpHit || (magicFrameReceived && !clr[`HMRFW_MPFR_BIT]);
         // RULE9: status and gated request
         wakeEventStatus <= pfHit || bcHit || wfHit || mpHit
            || (wakeEventStatus && !pmClr[`HMRFW_WAKESTS_BIT]);
         wakeRequest <= wakeEventStatus && wakeEventEnable;
         // RULE16: pointer walks on port access only
         if (softReset)
            filtPtr <= 6'h00;
         else if (wrPort || rdPort)
            filtPtr <= (filtPtr == `HMRFW_FILT_LAST) ? 6'h00 : filtPtr + 6'h01;
      end
   end

   // read channel: one read at a time, answered on the cycle after arrival
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `HMRFW_RESP_OKAY;
      end
      else if (rdDo)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `HMRFW_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         if (s_axi_araddr == `HMRFW_ADDR_RX_CFG)
            s_axi_rdata <= {29'h00000000, passBadFrames, broadcastDisable, receiveAllMode};
         else if (s_axi_araddr == `HMRFW_ADDR_FLOW)
            s_axi_rdata <= {31'h00000000, passControlFrames};
         else if (s_axi_araddr == `HMRFW_ADDR_STA_LOW)
            s_axi_rdata <= stationAddressLow;
         else if (s_axi_araddr == `HMRFW_ADDR_STA_HIGH)
            s_axi_rdata <= {16'h0000, stationAddressHigh};
         else if (s_axi_araddr == `HMRFW_ADDR_WAKE_CSR)
            s_axi_rdata <= {20'h00000, magicFrameReceived, wakeFrameReceived,
                            broadcastFrameReceived, perfectAddressFrameReceived,
                            3'h0, wakeWaitForSleep, magicPacketWakeEnable,
                            wakeFrameEnable, broadcastWakeEnable, perfectAddressWakeEnable};
         else if (s_axi_araddr == `HMRFW_ADDR_PM_CTRL)
            s_axi_rdata <= {30'h00000000, wakeEventStatus, wakeEventEnable};
         else if (s_axi_araddr == `HMRFW_ADDR_FILT_PORT)
            s_axi_rdata <= filtMem[filtPtr];
         else
            s_axi_rresp <= `HMRFW_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: tb/hmrfw_asserts.sv
// Purpose: checks on the verdict pulse and the bus handshakes
// Assumes: bound to hmrfw_core, one clock domain
// Notes: flags inside the core are not visible here
`timescale 1ns/1ps
`default_nettype none
module hmrfw_asserts (
   // clock and reset
   input wire logic ref_clk, rst_b,
   // bus handshakes
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   // frame link and verdict
   input wire logic rxValid, rxEof, addrFilterPass, statValid, statKeep,
   input wire logic statFilterFail, statPacketFilter, wakeRequest
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // verdict timing and address flag, tied to the last byte
   verdict_time_a: assert property (rxValid && rxEof |-> ##2 statValid)
      else $error("verdict pulse missing");
   fail_flag_a: assert property (rxValid && rxEof && !addrFilterPass |-> ##2 statFilterFail)
      else $error("fail flag missing");
   pass_flag_a: assert property (rxValid && rxEof && addrFilterPass |-> ##2 !statFilterFail)
      else $error("fail flag on pass");
   flags_hold_a: assert property (!statValid |-> $stable({statKeep, statFilterFail, statPacketFilter}))
      else $error("flags moved");
   // bus answers within the stated cycles
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not released");
   addr_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address taken twice");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[2:4] s_axi_bvalid)
      else $error("write answer late");
   cover property (statValid && statKeep);
   cover property (statValid && !statKeep);
   cover property (wakeRequest);
endmodule
bind hmrfw_core hmrfw_asserts i_chk (.*);
`default_nettype wire

// file: tb/hmrfw_frame_src.sv
// Purpose: fabric port model sending frames byte by byte
// Assumes: status is read by the core with the last byte only
// Notes: status lines carry the inverse on other bytes, data inverts when idle
`timescale 1ns/1ps
`default_nettype none
module hmrfw_frame_src (
   // clock
   input wire logic ref_clk,
   // byte link
   output var logic rxValid, rxSof, rxEof,
   output var logic [7:0] rxData,
   // frame status
   output var logic rxCrcErr, rxRunt, rxCollision, rxTooLong, rxControl, addrFilterPass
);
   // idle link at time zero
   initial
   begin
      {rxValid, rxSof, rxEof, rxData} = 11'h000;
      {addrFilterPass, rxControl, rxTooLong, rxCollision, rxRunt, rxCrcErr} = 6'h00;
   end
   // st is pass, control, too long, collision, runt, crc error
   task automatic send(input int n, input logic [47:0] da, input logic [5:0] st);
      for (int i = 0; i < n; i++)
      begin
         {rxValid, rxSof, rxEof} <= {1'h1, i == 0, i == n - 1};
         rxData <= i < 6 ? da[47 - 8 * i -: 8] : i[7:0];
         {addrFilterPass, rxControl, rxTooLong, rxCollision, rxRunt, rxCrcErr} <= i == n - 1 ? st : ~st;
         @(posedge ref_clk);
      end
      {rxValid, rxSof, rxEof} <= 3'h0;
      rxData <= ~rxData;
   endtask
endmodule
`default_nettype wire

// file: tb/host_mac_rx_filter_and_wake_detect_tb_top.sv
// Purpose: bench for receive acceptance and wake detection
// Assumes: bus tasks sample at the falling edge, drive after the rising edge
// Notes: byte strobes stay full
`timescale 1ns/1ps
`default_nettype none
`include "hmrfw_consts.vh"
module host_mac_rx_filter_and_wake_detect_tb_top;
   logic ref_clk = 1'h0, rst_b = 1'h0, powerDown = 1'h0, magicPacketDetect = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rxData;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rxValid, rxSof, rxEof, rxCrcErr, rxRunt, rxCollision, rxTooLong, rxControl, addrFilterPass;
   logic statValid, statKeep, statFilterFail, statPacketFilter, wakeRequest;
   int errors = 0, comparisons = 0, cycles = 0;
   localparam logic [47:0] stationDa = 48'h021122334455;
   hmrfw_core i_dut (.*);
   hmrfw_frame_src i_src (.*);
   always #12.5 ref_clk = ~ref_clk;
   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard, far above the expected run length
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         errors++;
         close_out;
      end
   end
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   // offsets past any frame leave the CRC at preset
   function automatic logic [31:0] fw(int i);
      return i > 33 && i % 2 == 0 ? '1 : 32'h01010101 * (i + 1);
   endfunction
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      logic [1:0] s;
      b = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!b)
      begin
         @(negedge ref_clk);
         {aw, w, b, s} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
      end
      chk("bresp", r, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ar, v;
      logic [33:0] s;
      v = 1'h0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!v)
      begin
         @(negedge ref_clk);
         {ar, v, s} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
         @(posedge ref_clk);
         if (ar) s_axi_arvalid <= 1'h0;
      end
      chk("read", {r, e}, s);
   endtask
   // e is keep, filter fail, packet filter
   task automatic frame(input int n, input logic [47:0] da, input logic [5:0] st, input logic [2:0] e);
      logic [2:0] s;
      s = 3'hx;
      i_src.send(n, da, st);
      repeat (3)
      begin
         @(negedge ref_clk);
         if (statValid === 1'h1) s = {statKeep, statFilterFail, statPacketFilter};
      end
      @(posedge ref_clk);
      chk("verdict", e, s);
   endtask
   initial
   begin
      int kd;
      logic p, ok, pf;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'h1;
      @(posedge ref_clk);
      for (int i = 0; i < 40; i++)
         wr(`HMRFW_ADDR_FILT_PORT, fw(i), 2'h0);
      for (int i = 0; i < 40; i++)
         rd(`HMRFW_ADDR_FILT_PORT, fw(i), 2'h0);
      wr(`HMRFW_ADDR_FILT_PORT, 32'hA5, 2'h0);
      wr(`HMRFW_ADDR_RX_CFG, 32'h80000000, 2'h0);
      rd(`HMRFW_ADDR_FILT_PORT, 32'hA5, 2'h0);
      wr(8'h1C, 32'h1, 2'h2);
      rd(8'h1C, 32'h0, 2'h2);
      wr(`HMRFW_ADDR_STA_LOW, 32'h33221102, 2'h0);
      wr(`HMRFW_ADDR_STA_HIGH, 32'h5544, 2'h0);
      $display("test register port done");
      // all mode mixes against five frame kinds
      for (int c = 0; c < 16; c++)
      begin
         wr(`HMRFW_ADDR_RX_CFG, c & 7, 2'h0);
         wr(`HMRFW_ADDR_FLOW, c / 8, 2'h0);
         for (int k = 0; k < 10; k++)
         begin
            {kd, p} = {k / 2, k[0]};
            ok = kd == 3 ? p | c[0] & c[2] : p | c[0];
            pf = kd == 1 ? !c[1] : kd == 2 ? c[3] : kd == 4 ? c[2] : 1'h1;
            frame(kd == 3 ? 60 : kd == 4 ? 61 : 64, kd == 1 ? '1 : stationDa,
               {p, kd == 2, kd > 2 ? 4'h1 << c % kd : 4'h0}, {ok, !p, pf});
         end
      end
      $display("test verdicts done");
      wr(`HMRFW_ADDR_RX_CFG, 32'h0, 2'h0);
      wr(`HMRFW_ADDR_WAKE_CSR, 32'h12, 2'h0);
      frame(64, '1, 6'h20, 3'h1);
      rd(`HMRFW_ADDR_WAKE_CSR, 32'h12, 2'h0);
      powerDown <= 1'h1;
      frame(64, '1, 6'h20, 3'h1);
      rd(`HMRFW_ADDR_PM_CTRL, 32'h2, 2'h0);
      @(negedge ref_clk) chk("wake", 1'h0, wakeRequest);
      @(posedge ref_clk) wr(`HMRFW_ADDR_PM_CTRL, 32'h1, 2'h0);
      repeat (2) @(negedge ref_clk);
      chk("wake", 1'h1, wakeRequest);
      @(posedge ref_clk);
      rd(`HMRFW_ADDR_WAKE_CSR, 32'h212, 2'h0);
      wr(`HMRFW_ADDR_WAKE_CSR, 32'h200, 2'h0);
      wr(`HMRFW_ADDR_PM_CTRL, 32'h2, 2'h0);
      frame(64, stationDa, 6'h20, 3'h5);
      wr(`HMRFW_ADDR_WAKE_CSR, 32'h1, 2'h0);
      frame(64, stationDa, 6'h20, 3'h1);
      rd(`HMRFW_ADDR_WAKE_CSR, 32'h101, 2'h0);
      wr(`HMRFW_ADDR_WAKE_CSR, 32'h10C, 2'h0);
      frame(64, stationDa, 6'h20, 3'h1);
      magicPacketDetect <= 1'h1;
      @(posedge ref_clk) magicPacketDetect <= 1'h0;
      rd(`HMRFW_ADDR_WAKE_CSR, 32'hC0C, 2'h0);
      rd(`HMRFW_ADDR_FILT_PORT, 32'h02020202, 2'h0);
      $display("test wake done");
      close_out;
   end
endmodule
`default_nettype wire
